/* dma_handshake_pkg.sv */
// package of constants for the external dma handshake port
`default_nettype none
package dma_handshake_pkg;
    localparam int ADDR_WIDTH       = 25;
    localparam int SELECT_WIDTH     = 4;
    localparam int DATA_WIDTH       = 32;
    localparam int WAIT_WIDTH       = 5;
    localparam int IDLE_CYCLES      = 1;
    localparam logic [1:0] MODE_HANDSHAKE = 2'h0;
    localparam logic [1:0] MODE_EXTERNAL  = 2'h1;
    localparam logic [1:0] MODE_PACED     = 2'h2;
    localparam logic [SELECT_WIDTH-1:0] SELECT_IDLE = 4'hf;
endpackage
`default_nettype wire

/* dma_request_sync.sv */
// two-stage synchroniser with falling-edge detect for the request pin
`default_nettype none
module dma_request_sync
    import dma_handshake_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    input  wire logic pin_n,
    output logic      level_n,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // two flops, then an edge detector on the second only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else if (clk_en) begin
            meta_q <= pin_n;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_n = sync_q;
    assign fall    = last_q & ~sync_q;
endmodule
`default_nettype wire

/* dma_handshake_port.sv */
// external dma request and grant handshake engine
// Notes on behaviour
// - transfers start only on request low
// - handshake mode drives grant strobe to peripheral
// - external mode uses address, read, selects, ack, grant
// - paced master uses bus strobes, never grant
// - paced master cycles match ordinary bus cycles
// - request meeting setup recognised two edges later, after the two-flop synchroniser
// - held request stretches write grant until release
// - held request stretches read grant until release
// - wait states lengthen grant low time
// - idle cycle extends grant high time
`default_nettype none
module dma_handshake_port
    import dma_handshake_pkg::*;
#(
    parameter int AW = ADDR_WIDTH,
    parameter int DW = DATA_WIDTH,
    parameter int WW = WAIT_WIDTH
) (
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    input  wire logic                    clk_en,
    input  wire logic [1:0]              mode,
    input  wire logic [WW-1:0]           wait_states,
    input  wire logic                    idle_enable,
    input  wire logic                    dir_read,
    input  wire logic [AW-1:0]           xfer_addr,
    input  wire logic [SELECT_WIDTH-1:0] xfer_select,
    input  wire logic [DW-1:0]           wr_data,
    input  wire logic                    dma_request_n,
    input  wire logic                    ack,
    input  wire logic [DW-1:0]           data_in,
    output logic                         dma_grant_n,
    output logic                         rd_n,
    output logic                         wr_n,
    output logic [AW-1:0]                addr,
    output logic                         addr_oe,
    output logic [SELECT_WIDTH-1:0]      memory_select_n,
    output logic [DW-1:0]                data_out,
    output logic                         data_oe,
    output logic [DW-1:0]                rd_data,
    output logic                         rd_valid,
    output logic                         busy
);
    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_STROBE = 5'b00010,
        S_HOLD   = 5'b00100,
        S_ACK    = 5'b01000,
        S_GAP    = 5'b10000
    } state_type;

    state_type       state_q;
    logic [WW-1:0]   wait_q;
    logic            gap_q;
    logic            pend_q;
    logic            req_level_n;
    logic            req_fall;
    logic            is_paced;
    logic            is_read_q;
    logic            ack_meta_q;
    logic            ack_sync_q;
    logic            start_now;
    logic            hs_release;
    logic            ack_done;
    logic            release_now;
    logic            read_done;
    logic            uses_bus;
    logic            rd_strobe_d;
    logic            wr_strobe_d;

    // request pin synchroniser
    dma_request_sync u_req_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .pin_n   (dma_request_n),
        .level_n (req_level_n),
        .fall    (req_fall)
    );

    // ack pin synchroniser
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
        end else if (clk_en) begin
            ack_meta_q <= ack;
            ack_sync_q <= ack_meta_q;
        end
    end

    assign is_paced = (mode == MODE_PACED);

    // pending request: falling edge caught now, or kept for next slot
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_q <= 1'b0;
        end else if (clk_en) begin
            // only an edge seen while busy is kept; an idle edge starts at once
            if (req_fall && state_q != S_IDLE) begin
                pend_q <= 1'b1;
            end else if (state_q == S_IDLE && pend_q) begin
                pend_q <= 1'b0;
            end
        end
    end

    // transfer sequencer
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q   <= S_IDLE;
            wait_q    <= '0;
            gap_q     <= 1'b0;
            is_read_q <= 1'b0;
        end else if (clk_en) begin
            unique case (state_q)
                S_IDLE: begin
                    if (pend_q || req_fall) begin
                        state_q   <= S_STROBE;
                        wait_q    <= wait_states;
                        is_read_q <= dir_read;
                    end
                end
                S_STROBE: begin
                    if (wait_q != '0) begin
                        wait_q <= wait_q - 1'b1;
                    end else begin
                        state_q <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    // request held low stretches the access in handshake and external modes
                    if (!req_level_n && !is_paced) begin
                        state_q <= S_HOLD;
                    end else if (is_paced || mode == MODE_EXTERNAL) begin
                        state_q <= S_ACK;
                    end else begin
                        state_q <= S_GAP;
                        gap_q   <= idle_enable;
                    end
                end
                S_ACK: begin
                    // bus slave ack gates completion as in normal cycles
                    if (ack_sync_q) begin
                        state_q <= S_GAP;
                        gap_q   <= idle_enable;
                    end
                end
                S_GAP: begin
                    if (gap_q) begin
                        gap_q <= 1'b0;
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // launch and completion conditions shared by the output flops
    assign start_now   = (state_q == S_IDLE) && (pend_q || req_fall);
    assign hs_release  = (state_q == S_HOLD) && (mode == MODE_HANDSHAKE) && req_level_n;
    assign ack_done    = (state_q == S_ACK) && ack_sync_q;
    assign release_now = (state_q == S_GAP) || ack_done || hs_release;
    assign read_done   = is_read_q && (hs_release || ack_done);
    assign uses_bus    = (mode != MODE_HANDSHAKE);

    // strobe levels for the launched cycle, active low on the pins
    assign rd_strobe_d = ~(dir_read && uses_bus);
    assign wr_strobe_d = ~(!dir_read && is_paced);

    // grant strobe: driven low in handshake and external modes only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_grant_n <= 1'b1;
        end else if (clk_en) begin
            if (start_now) begin
                dma_grant_n <= is_paced;
            end else if (release_now) begin
                dma_grant_n <= 1'b1;
            end
        end
    end

    // read strobe for external and paced reads
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_n <= 1'b1;
        end else if (clk_en) begin
            if (start_now) begin
                rd_n <= rd_strobe_d;
            end else if (release_now) begin
                rd_n <= 1'b1;
            end
        end
    end

    // write strobe, used by paced master writes only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_n <= 1'b1;
        end else if (clk_en) begin
            if (start_now) begin
                wr_n <= wr_strobe_d;
            end else if (release_now) begin
                wr_n <= 1'b1;
            end
        end
    end

    // address word, latched at launch and held through the access
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr <= '0;
        end else if (clk_en) begin
            if (start_now) begin
                addr <= xfer_addr;
            end
        end
    end

    // address enable: only the bus-style modes drive the address
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_oe <= 1'b0;
        end else if (clk_en) begin
            if (start_now) begin
                addr_oe <= uses_bus;
            end else if (release_now) begin
                addr_oe <= 1'b0;
            end
        end
    end

    // memory selects, inverted onto the active-low pins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            memory_select_n <= SELECT_IDLE;
        end else if (clk_en) begin
            if (start_now) begin
                memory_select_n <= uses_bus ? ~xfer_select : SELECT_IDLE;
            end else if (release_now) begin
                memory_select_n <= SELECT_IDLE;
            end
        end
    end

    // write data word, latched at launch
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out <= '0;
        end else if (clk_en) begin
            if (start_now) begin
                data_out <= wr_data;
            end
        end
    end

    // write data enable; off again as the grant ends
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_oe <= 1'b0;
        end else if (clk_en) begin
            if (start_now) begin
                data_oe <= ~dir_read;
            end else if (release_now) begin
                data_oe <= 1'b0;
            end
        end
    end

    // read data captured as a read ends, at handshake release or synchronised ack, in every mode
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else if (clk_en) begin
            if (read_done) begin
                rd_data <= data_in;
            end
        end
    end

    // one-cycle pulse marking fresh read data
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_valid <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= read_done;
        end
    end

    assign busy = (state_q != S_IDLE);
endmodule
`default_nettype wire

/* dma_handshake_props.sv */
// assertion checker for the dma handshake port
`default_nettype none
module hs_props
    import dma_handshake_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  arst_n,
    input wire logic [1:0]            mode,
    input wire logic [WAIT_WIDTH-1:0] wait_states,
    input wire logic                  dir_read,
    input wire logic                  dma_request_n,
    input wire logic                  dma_grant_n,
    input wire logic                  rd_n,
    input wire logic                  wr_n,
    input wire logic                  rd_valid,
    input wire logic                  busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic [7:0] low_q;
    // cycles the grant has stayed low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            low_q <= 8'h00;
        else
            low_q <= dma_grant_n ? 8'h00 : low_q + 8'h01;
    end
    // handshake timing relations
    chk_idle_quiet: assert property (!busy |-> dma_grant_n && rd_n && wr_n) else $error("strobe while idle");
    chk_start_delay: assert property ($fell(dma_request_n) && !busy && mode == MODE_HANDSHAKE |->
        ##[2:5] !dma_grant_n) else $error("grant late");
    chk_min_low: assert property ($rose(dma_grant_n) |-> low_q >= 8'(wait_states) + 8'h01) else $error("grant short");
    chk_hold_grant: assert property (mode == MODE_HANDSHAKE && !dma_grant_n && !dma_request_n
        && $past(!dma_request_n) && $past(!dma_request_n, 2) |=> !dma_grant_n) else $error("grant dropped");
    chk_grant_release: assert property (mode == MODE_HANDSHAKE && wait_states == 5'h00 && !dma_grant_n
        && $rose(dma_request_n) |-> ##[2:4] dma_grant_n) else $error("grant stuck");
    chk_paced_grant: assert property (mode == MODE_PACED |-> dma_grant_n) else $error("paced grant");
    chk_read_pulse: assert property (rd_valid |=> !rd_valid) else $error("long read pulse");
    chk_read_only: assert property (rd_valid |-> dir_read) else $error("read pulse on write");
endmodule
`default_nettype wire

/* periph_model.sv */
// peripheral model answering the dma handshake
`default_nettype none
module periph_model
    import dma_handshake_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  go,
    input wire logic [7:0]            hold,
    input wire logic                  dma_grant_n,
    input wire logic                  rd_n,
    input wire logic                  wr_n,
    input wire logic [DATA_WIDTH-1:0] rd_word,
    output var logic                  dma_request_n,
    output var logic                  ack,
    output logic [DATA_WIDTH-1:0]     data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] n_q = 8'h00;
    initial dma_request_n = 1'b1;
    initial ack = 1'b0;
    // request on demand, release after hold cycles of strobe
    always @(posedge sys_clk) begin
        if (go)
            dma_request_n <= 1'b0;
        else if (!(dma_grant_n && rd_n && wr_n)) begin
            n_q <= n_q + 8'h01;
            if (n_q >= hold) begin
                dma_request_n <= 1'b1;
                ack <= 1'b1;
            end
        end else begin
            n_q <= 8'h00;
            ack <= 1'b0;
        end
    end
    // read word only while selected, inverted otherwise
    assign data_in = (!dma_grant_n || !rd_n) ? rd_word : ~rd_word;
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking testbench for the dma handshake port
`default_nettype none
module testbench
    import dma_handshake_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    sys_clk = 1'b0, arst_n = 1'b0, idle_enable = 1'b0, dir_read = 1'b0, go = 1'b0;
    logic                    dma_request_n, ack, dma_grant_n, rd_n, wr_n, rd_valid, busy;
    logic [1:0]              mode = MODE_HANDSHAKE;
    logic [WAIT_WIDTH-1:0]   wait_states = 5'h00;
    logic [ADDR_WIDTH-1:0]   xfer_addr = 25'h0abcdef;
    logic [SELECT_WIDTH-1:0] xfer_select = 4'h2, memory_select_n;
    logic [DATA_WIDTH-1:0]   wr_data = 32'h0, rd_word = 32'h0, data_in, rd_data, data_out;
    logic [ADDR_WIDTH-1:0]   addr;
    logic                    addr_oe, data_oe;
    logic [7:0]              hold = 8'h00;
    int                      fails = 0, cmp_count = 0;
    dma_handshake_port dut_u (
        .sys_clk         (sys_clk),
        .arst_n          (arst_n),
        .clk_en          (1'b1),
        .mode            (mode),
        .wait_states     (wait_states),
        .idle_enable     (idle_enable),
        .dir_read        (dir_read),
        .xfer_addr       (xfer_addr),
        .xfer_select     (xfer_select),
        .wr_data         (wr_data),
        .dma_request_n   (dma_request_n),
        .ack             (ack),
        .data_in         (data_in),
        .dma_grant_n     (dma_grant_n),
        .rd_n            (rd_n),
        .wr_n            (wr_n),
        .addr            (addr),
        .addr_oe         (addr_oe),
        .memory_select_n (memory_select_n),
        .data_out        (data_out),
        .data_oe         (data_oe),
        .rd_data         (rd_data),
        .rd_valid        (rd_valid),
        .busy            (busy)
    );
    periph_model peer_u (
        .sys_clk       (sys_clk),
        .go            (go),
        .hold          (hold),
        .dma_grant_n   (dma_grant_n),
        .rd_n          (rd_n),
        .wr_n          (wr_n),
        .rd_word       (rd_word),
        .dma_request_n (dma_request_n),
        .ack           (ack),
        .data_in       (data_in)
    );
    initial forever #10 sys_clk = ~sys_clk;
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one transfer: counts grant, strobe and read pulses
    task automatic xfer(input logic [1:0] m, input logic rd, input int ws, input int h);
        int lo = 0, st = 0, rv = 0, oc = 0;
        logic [SELECT_WIDTH-1:0] sel_exp;
        sel_exp = (m != MODE_HANDSHAKE) ? ~xfer_select : SELECT_IDLE;
        @(posedge sys_clk);
        mode <= m;
        dir_read <= rd;
        wait_states <= ws[WAIT_WIDTH-1:0];
        hold <= h[7:0];
        wr_data <= 32'h5a0fc300 ^ 32'(h);
        rd_word <= 32'h3c0f00a5 ^ 32'(ws);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        for (int k = 0; k < 300 && (k < 6 || busy !== 1'b0); k++) begin
            @(posedge sys_clk);
            #1;
            lo += int'(dma_grant_n === 1'b0);
            st += int'(rd_n === 1'b0 || wr_n === 1'b0);
            rv += int'(rd_valid === 1'b1);
            if (rd_valid === 1'b1)
                compare(rd_data, rd_word);
            if (oc == 0 && (dma_grant_n === 1'b0 || rd_n === 1'b0 || wr_n === 1'b0)) begin
                oc = 1;
                compare(32'({addr_oe, data_oe, memory_select_n}), 32'({m != MODE_HANDSHAKE, !rd, sel_exp}));
                compare(data_out, wr_data);
                if (m != MODE_HANDSHAKE)
                    compare(32'(addr), 32'(xfer_addr));
            end
        end
        compare(32'({busy, addr_oe, data_oe, memory_select_n}), 32'h0000000f);
        if (m == MODE_PACED)
            compare(32'({lo == 0, st > 0}), 32'h3);
        else
            compare(32'(lo > h && lo > ws), 32'h1);
        compare(32'(rv), 32'(rd));
    endtask
    task t_handshake();
        xfer(MODE_HANDSHAKE, 1'b0, 0, 0);
        xfer(MODE_HANDSHAKE, 1'b0, 0, 6);
        xfer(MODE_HANDSHAKE, 1'b0, 31, 0);
        xfer(MODE_HANDSHAKE, 1'b1, 2, 5);
        $display("handshake done");
    endtask
    task t_external_paced();
        xfer(MODE_EXTERNAL, 1'b1, 0, 2);
        xfer(MODE_EXTERNAL, 1'b0, 1, 0);
        xfer(MODE_PACED, 1'b0, 0, 0);
        xfer(MODE_PACED, 1'b1, 0, 1);
        $display("external and paced done");
    endtask
    task t_idle_gap();
        @(posedge sys_clk);
        idle_enable <= 1'b1;
        xfer(MODE_HANDSHAKE, 1'b0, 1, 0);
        xfer(MODE_HANDSHAKE, 1'b1, 0, 0);
        $display("idle gap done");
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_handshake();
        t_external_paced();
        t_idle_gap();
        give_verdict();
    end
    // watchdog: ten transfers need well under a thousand cycles
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule
bind dma_handshake_port hs_props chk_u (.*);
`default_nettype wire
